// [core/sfm_flash.sv]
// Serial flash target: discovery table read and pin lane control
// Assumes the serial clock is slower than a quarter of the 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module sfm_flash
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic lane_zero_in,
	output logic lane_zero_out,
	output logic lane_zero_oe_n,
	input wire logic lane_one_in,
	output logic lane_one_out,
	output logic lane_one_oe_n,
	input wire logic lane_two_in,
	output logic lane_two_out,
	output logic lane_two_oe_n,
	input wire logic lane_three_in,
	output logic lane_three_out,
	output logic lane_three_oe_n,
	input wire logic quad_enable,
	input wire logic dual_mode,
	input wire logic four_lane_instruction_mode,
	input wire logic dedicated_reset_enable,
	input wire logic pin_function_select,
	input wire logic [23:0] probe_address,
	output logic [10:0] probe_sector,
	output logic [7:0] probe_block32,
	output logic [6:0] probe_block64,
	output logic probe_in_range,
	output logic pin_reset_active,
	output logic hold_active,
	output logic [7:0] last_byte_sent,
	output logic byte_sent_pulse
);
	import sfm_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] meta_ff;
	logic [4:0] sync_ff;
	logic sck_prev_ff;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_ff <= 5'h1_F;
			sync_ff <= 5'h1_F;
			sck_prev_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= {lane_three_in, lane_zero_in, chip_select_n, serial_clock, 1'b1};
			sync_ff <= meta_ff;
			sck_prev_ff <= sync_ff[1];
		end
	end
	wire sck_s = sync_ff[1];
	wire cs_n_s = sync_ff[2];
	wire si_s = sync_ff[3];
	wire pause_pin_s = sync_ff[4];

	// Pause pin role; quad use or reset role means no pause
	wire pause_role = !quad_enable && (dedicated_reset_enable || !pin_function_select);
	wire reset_role = !quad_enable && !dedicated_reset_enable && pin_function_select;
	wire paused = pause_role && !pause_pin_s && !cs_n_s;
	wire pin_reset = reset_role && !pause_pin_s;
	// Mode 3 idles high: first falling edge then precedes first rise, harmless
	wire rise = sck_s && !sck_prev_ff && !cs_n_s && !paused && !pin_reset;
	wire fall = !sck_s && sck_prev_ff && !cs_n_s && !paused && !pin_reset;

	// ****************************************
	// Address map
	// ****************************************
	assign probe_sector = probe_address[22:12];
	assign probe_block32 = probe_address[22:15];
	assign probe_block64 = probe_address[22:16];
	assign probe_in_range = probe_address <= SFM_LAST_ADDR;
	assign pin_reset_active = pin_reset;
	assign hold_active = paused;

	// ****************************************
	// Discovery table lookup
	// ****************************************
	function automatic logic [7:0] table_byte(input logic [23:0] a);
		if (a[23:4] == 20'h0_0000)
			table_byte = SFM_HEADER_BYTES[a[3:0]*8 +: 8];
		else if (a[23:4] == 20'h0_0003)
			table_byte = SFM_TABLE_BYTES[a[3:0]*8 +: 8];
		else
			table_byte = SFM_FILL_BYTE;
	endfunction

	// ****************************************
	// Serial command sequencer
	// ****************************************
	sfm_state_type state_ff;
	logic [5:0] bit_cnt_ff;
	logic [23:0] addr_ff;
	logic [7:0] shift_ff;
	logic [7:0] out_ff;
	logic [2:0] out_cnt_ff;
	logic drive_ff;
	logic [7:0] buf_data_ff [2];
	logic [1:0] buf_cnt_ff;
	logic buf_rd_ff;
	logic buf_wr_ff;
	wire lane_in = four_lane_instruction_mode ? 1'b0 : si_s;
	wire buf_in_ready = buf_cnt_ff != 2'd2;
	wire buf_out_valid = buf_cnt_ff != 2'd0;
	wire want_byte = (state_ff == SFM_ST_DATA) && buf_in_ready && !buf_wr_ff;
	wire take_byte = fall && (out_cnt_ff == 3'd0) && buf_out_valid;
	logic [7:0] nxt_shift;
	assign nxt_shift = {shift_ff[6:0], lane_in};

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff <= SFM_ST_CMD;
			bit_cnt_ff <= 6'd0;
			addr_ff <= 24'h00_0000;
			shift_ff <= 8'h00;
			buf_wr_ff <= 1'b0;
		end
		else if (cs_n_s || pin_reset)
		begin
			state_ff <= SFM_ST_CMD;
			bit_cnt_ff <= 6'd0;
			buf_wr_ff <= 1'b0;
		end
		else
		begin
			buf_wr_ff <= want_byte;
			if (want_byte)
				addr_ff <= addr_ff + 24'h00_0001;
			if (rise)
			begin
				shift_ff <= nxt_shift;
				bit_cnt_ff <= bit_cnt_ff + 6'd1;
				case (state_ff)
					SFM_ST_CMD:
						if (bit_cnt_ff == 6'd7)
						begin
							bit_cnt_ff <= 6'd0;
							state_ff <= (nxt_shift == SFM_CMD_DISCOVER) ? SFM_ST_ADDR : SFM_ST_DATA;
						end
					SFM_ST_ADDR:
					begin
						addr_ff <= {addr_ff[22:0], lane_in};
						if (bit_cnt_ff == 6'(SFM_ADDR_BITS - 1))
						begin
							bit_cnt_ff <= 6'd0;
							state_ff <= SFM_ST_DUMMY;
						end
					end
					SFM_ST_DUMMY:
						if (bit_cnt_ff == 6'(SFM_DUMMY_BITS - 1))
							state_ff <= SFM_ST_DATA;
					default:
						bit_cnt_ff <= 6'd0;
				endcase
			end
		end
	end

	// Two-entry buffer between the table and the shifter
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			buf_cnt_ff <= 2'd0;
			buf_rd_ff <= 1'b0;
			buf_data_ff[0] <= 8'h00;
			buf_data_ff[1] <= 8'h00;
		end
		else if (cs_n_s || pin_reset)
		begin
			buf_cnt_ff <= 2'd0;
			buf_rd_ff <= 1'b0;
		end
		else
		begin
			if (buf_wr_ff)
				buf_data_ff[buf_rd_ff ^ buf_cnt_ff[0]] <= table_byte(addr_ff - 24'h00_0001);
			if (take_byte)
				buf_rd_ff <= !buf_rd_ff;
			buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_wr_ff} - {1'b0, take_byte};
		end
	end

	// Output shifter: a new bit only after a falling edge
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_ff <= 8'hFF;
			out_cnt_ff <= 3'd0;
			drive_ff <= 1'b0;
			last_byte_sent <= 8'h00;
			byte_sent_pulse <= 1'b0;
		end
		else
		begin
			byte_sent_pulse <= take_byte;
			if (cs_n_s || pin_reset || state_ff != SFM_ST_DATA)
			begin
				drive_ff <= 1'b0;
				out_cnt_ff <= 3'd0;
			end
			else if (take_byte)
			begin
				out_ff <= buf_data_ff[buf_rd_ff];
				last_byte_sent <= buf_data_ff[buf_rd_ff];
				out_cnt_ff <= 3'd7;
				drive_ff <= 1'b1;
			end
			else if (fall && out_cnt_ff != 3'd0)
			begin
				out_ff <= {out_ff[6:0], 1'b1};
				out_cnt_ff <= out_cnt_ff - 3'd1;
			end
		end
	end

	// ****************************************
	// Lane drive
	// ****************************************
	wire multi = dual_mode || quad_enable || four_lane_instruction_mode;
	wire quad = quad_enable || four_lane_instruction_mode;
	assign lane_one_out = out_ff[7];
	assign lane_one_oe_n = !(drive_ff && !paused && !cs_n_s);
	assign lane_zero_out = 1'b1;
	assign lane_zero_oe_n = 1'b1; // single-bit table only drives lane one
	assign lane_two_out = 1'b1;
	assign lane_two_oe_n = 1'b1;
	assign lane_three_out = 1'b1;
	assign lane_three_oe_n = 1'b1;
	wire unused_ok = multi ^ quad ^ lane_one_in ^ lane_two_in;

	// ****************************************
	// Checks
	// ****************************************
	property p_float_when_deselected;
		@(posedge clock) disable iff (!reset_n) cs_n_s |-> lane_one_oe_n;
	endproperty
	a_float_when_deselected: assert property (p_float_when_deselected) else $error("output driven while deselected");
	property p_float_when_paused;
		@(posedge clock) disable iff (!reset_n) paused |-> lane_one_oe_n;
	endproperty
	a_float_when_paused: assert property (p_float_when_paused) else $error("output driven while paused");
	property p_out_changes_on_fall;
		@(posedge clock) disable iff (!reset_n) $changed(out_ff) |-> $past(fall);
	endproperty
	a_out_changes_on_fall: assert property (p_out_changes_on_fall) else $error("output moved without falling edge");
	property p_shift_on_rise;
		@(posedge clock) disable iff (!reset_n) $changed(shift_ff) |-> $past(rise);
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise) else $error("input sampled off rising edge");
	// First fill of a frame lands in entry zero; from address zero it must be the signature
	property p_signature;
		@(posedge clock) disable iff (!reset_n) buf_wr_ff && !cs_n_s && !pin_reset && addr_ff == 24'h00_0001
			&& buf_cnt_ff == 2'd0 && !buf_rd_ff |=> buf_data_ff[0] == 8'h53;
	endproperty
	a_signature: assert property (p_signature) else $error("signature byte wrong");
	property p_fill;
		@(posedge clock) disable iff (!reset_n) table_byte(24'h00_0040) == 8'hFF && table_byte(24'h00_0010) == 8'hFF;
	endproperty
	a_fill: assert property (p_fill) else $error("fill byte wrong");
	property p_pointer;
		@(posedge clock) disable iff (!reset_n) table_byte(24'h00_000C) == 8'h30 && table_byte(24'h00_000B) == 8'h10;
	endproperty
	a_pointer: assert property (p_pointer) else $error("header pointer wrong");
	property p_table;
		@(posedge clock) disable iff (!reset_n) table_byte(24'h00_0030) == 8'hE5 && table_byte(24'h00_0039) == 8'hEB
			&& table_byte(24'h00_003F) == 8'hBB && table_byte(24'h00_0037) == 8'h03;
	endproperty
	a_table: assert property (p_table) else $error("basic table wrong");
	property p_buffer_bound;
		@(posedge clock) disable iff (!reset_n) buf_cnt_ff <= 2'd2;
	endproperty
	a_buffer_bound: assert property (p_buffer_bound) else $error("buffer overflow");
	c_byte_sent: cover property (@(posedge clock) disable iff (!reset_n) byte_sent_pulse);
	c_paused: cover property (@(posedge clock) disable iff (!reset_n) paused && drive_ff);
	c_buffer_full: cover property (@(posedge clock) disable iff (!reset_n) buf_cnt_ff == 2'd2);
endmodule
`default_nettype wire

// [core/sfm_pkg.sv]
// Constants of the serial flash discovery block
// Assumes a single 40 MHz system clock samples the serial link
package sfm_pkg;
	// ****************************************
	// Link and discovery constants
	// ****************************************
	localparam logic [7:0] SFM_CMD_DISCOVER = 8'h5A;
	localparam int SFM_ADDR_BITS = 24;
	localparam int SFM_DUMMY_BITS = 8;
	localparam logic [23:0] SFM_SECTOR_BYTES = 24'h00_1000;
	localparam logic [23:0] SFM_BLOCK32_BYTES = 24'h00_8000;
	localparam logic [23:0] SFM_BLOCK64_BYTES = 24'h01_0000;
	localparam logic [23:0] SFM_LAST_ADDR = 24'h7F_FFFF;
	localparam logic [10:0] SFM_LAST_SECTOR = 11'h7FF;
	localparam logic [7:0] SFM_FILL_BYTE = 8'hFF;
	localparam logic [7:0] SFM_TABLE_BASE = 8'h30;
	localparam logic [7:0] SFM_TABLE_END = 8'h3F;
	// Signature and header, bytes 00h..0Fh
	localparam logic [127:0] SFM_HEADER_BYTES = 128'hFF00_0030_1001_0600_FF00_0106_5044_4653;
	// Basic table bytes 30h..3Fh, byte 30h in the low lane
	localparam logic [127:0] SFM_TABLE_BYTES = 128'hBB80_3B08_6B08_EB44_03FF_FFFF_FFF9_20E5;
	typedef enum logic [1:0] {SFM_ST_CMD = 2'b00, SFM_ST_ADDR = 2'b01, SFM_ST_DUMMY = 2'b11,
		SFM_ST_DATA = 2'b10} sfm_state_type;
endpackage

// [verification/sfm_spi_master.sv]
// Master model that runs discovery reads over the serial link
// Assumes the target shifts on falling and samples on rising edges
`timescale 1ns/1ps
`default_nettype none
module sfm_spi_master
(
	input wire logic mode3,
	input wire logic lane_one,
	output logic serial_clock,
	output logic chip_select_n,
	output logic lane_zero,
	output logic hold_n
);
	logic [7:0] rx_q[$];
	initial
	begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		lane_zero = 1'b1;
		hold_n = 1'b1;
	end
	// ****************************************
	// Bit and frame sequencing
	// ****************************************
	// Data changes while the clock is low, read back at the rise
	task automatic bit_cycle(input logic b, output logic s);
		serial_clock = 1'b0;
		lane_zero = b;
		#100;
		serial_clock = 1'b1;
		s = lane_one;
		#100;
	endtask
	task automatic read_bytes(input logic [23:0] addr, input int count, input int pause_at);
		logic [39:0] hdr;
		logic [7:0] b;
		logic s;
		hdr = {8'h5A, addr, 8'h00};
		rx_q.delete();
		serial_clock = mode3;
		#200;
		chip_select_n = 1'b0;
		#100;
		for (int i = 39; i >= 0; i--)
			bit_cycle(hdr[i], s);
		for (int n = 0; n < count; n++)
		begin
			// Pause with the clock parked high, the target must keep its place
			if (n == pause_at)
			begin
				hold_n = 1'b0;
				#600;
				hold_n = 1'b1;
				#200;
			end
			for (int i = 7; i >= 0; i--)
				bit_cycle(~lane_zero, b[i]);
			rx_q.push_back(b);
		end
		serial_clock = mode3;
		#100;
		chip_select_n = 1'b1;
		lane_zero = ~lane_zero;
		#200;
	endtask
endmodule
`default_nettype wire

// [verification/sfm_flash_tb.sv]
// Self-checking bench for the discovery read block
// Assumes a 40 MHz clock and the master model's 200 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module sfm_flash_tb;
	logic clock;
	logic reset_n;
	logic mode3;
	logic tb_pin3;
	logic quad_enable;
	logic dedicated_reset_enable;
	logic pin_function_select;
	logic [23:0] probe_address;
	wire logic sck, cs_n, lane_zero, hold_n, lane_one, lane_one_out, pin_reset_active, probe_in_range;
	wire logic lane_zero_oe_n, lane_one_oe_n, lane_two_oe_n, lane_three_oe_n;
	wire logic [10:0] probe_sector;
	wire logic [7:0] probe_block32;
	wire logic [6:0] probe_block64;
	wire logic hold_active, byte_sent_pulse;
	wire logic [7:0] last_byte_sent;
	int sent_count = 0;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// Pull-up on the output lane once it is released
	assign lane_one = lane_one_oe_n ? 1'b1 : lane_one_out;
	sfm_spi_master master (.mode3(mode3), .lane_one(lane_one), .serial_clock(sck), .chip_select_n(cs_n),
		.lane_zero(lane_zero), .hold_n(hold_n));
	sfm_flash dut (.clock(clock), .reset_n(reset_n), .serial_clock(sck), .chip_select_n(cs_n),
		.lane_zero_in(lane_zero), .lane_zero_out(), .lane_zero_oe_n(lane_zero_oe_n),
		.lane_one_in(lane_one), .lane_one_out(lane_one_out), .lane_one_oe_n(lane_one_oe_n),
		.lane_two_in(1'b1), .lane_two_out(), .lane_two_oe_n(lane_two_oe_n),
		.lane_three_in(hold_n & tb_pin3), .lane_three_out(), .lane_three_oe_n(lane_three_oe_n),
		.quad_enable(quad_enable), .dual_mode(1'b0), .four_lane_instruction_mode(1'b0),
		.dedicated_reset_enable(dedicated_reset_enable), .pin_function_select(pin_function_select),
		.probe_address(probe_address), .probe_sector(probe_sector), .probe_block32(probe_block32),
		.probe_block64(probe_block64), .probe_in_range(probe_in_range), .pin_reset_active(pin_reset_active),
		.hold_active(hold_active), .last_byte_sent(last_byte_sent), .byte_sent_pulse(byte_sent_pulse));
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ****************************************
	// Reporting
	// ****************************************
	task automatic end_sim();
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (byte_sent_pulse)
			sent_count <= sent_count + 1;
		if (cycles == 20000)
		begin
			err_count++;
			end_sim();
		end
	end
	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Expected bytes packed first byte leftmost
	task automatic check_rx(input string what, input logic [143:0] exp, input int n);
		check_val({what, " count"}, n, master.rx_q.size());
		for (int i = 0; i < n && i < master.rx_q.size(); i++)
			check_val(what, exp[8 * (n - 1 - i) +: 8], master.rx_q[i]);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_map();
		logic [23:0] a[7] = '{24'h00_0000, 24'h00_0FFF, 24'h00_1000, 24'h00_FFFF, 24'h3F_0000, 24'h7F_FFFF,
			24'h80_0000};
		for (int i = 0; i < 7; i++)
		begin
			@(posedge clock);
			#2 probe_address = a[i];
			#5 check_val("in range", a[i] <= 24'h7F_FFFF, probe_in_range);
			if (i < 6)
			begin
				check_val("sector", a[i] / 24'h00_1000, probe_sector);
				check_val("block32", a[i] / 24'h00_8000, probe_block32);
				check_val("block64", a[i] / 24'h01_0000, probe_block64);
			end
		end
	endtask
	task automatic test_pins();
		// Shared pin passes the synchroniser first; the role inputs are plain levels
		@(posedge clock);
		#2 tb_pin3 = 1'b0;
		repeat (3) @(posedge clock);
		for (int v = 0; v < 8; v++)
		begin
			@(posedge clock);
			#2 {quad_enable, dedicated_reset_enable, pin_function_select} = v[2:0];
			#5 check_val("reset role", v == 1, pin_reset_active);
		end
		@(posedge clock);
		#2 {quad_enable, dedicated_reset_enable, pin_function_select, tb_pin3} = 4'h1;
		repeat (4) @(posedge clock);
	endtask
	task automatic test_header();
		@(posedge clock);
		#2 mode3 = 1'b0;
		master.read_bytes(24'h00_0000, 16, -1);
		check_rx("header", 128'h5346_4450_0601_00FF_0006_0110_3000_00FF, 16);
	endtask
	task automatic test_pause();
		@(posedge clock);
		#2 mode3 = 1'b0;
		fork
			master.read_bytes(24'h00_0008, 4, 2);
			begin
				wait (hold_n == 1'b0);
				#400 check_val("paused oe_n", 1'b1, lane_one_oe_n);
				check_val("hold active", 1'b1, hold_active);
			end
		join
		check_rx("paused read", 32'h0006_0110, 4);
		// Mode 0 parks the clock low before deselect, so one more byte goes out
		check_val("last byte", 8'h30, last_byte_sent);
	endtask
	task automatic test_table();
		int sent_before;
		@(posedge clock);
		#2 mode3 = 1'b1;
		sent_before = sent_count;
		master.read_bytes(24'h00_0030, 18, -1);
		check_rx("table", 144'hE520_F9FF_FFFF_FF03_44EB_086B_083B_80BB_FFFF, 18);
		check_val("bytes sent", 18, sent_count - sent_before);
		check_val("idle oe_n", 4'hF, {lane_zero_oe_n, lane_one_oe_n, lane_two_oe_n, lane_three_oe_n});
	endtask
	initial
	begin
		reset_n = 1'b0;
		mode3 = 1'b0;
		tb_pin3 = 1'b1;
		{quad_enable, dedicated_reset_enable, pin_function_select} = 3'h0;
		probe_address = 24'h00_0000;
		repeat (5) @(posedge clock);
		#2 reset_n = 1'b1;
		repeat (4) @(posedge clock);
		test_map();
		test_pins();
		test_header();
		test_pause();
		test_table();
		end_sim();
	end
endmodule
`default_nettype wire
